// ---- design/fcs_regs.sv ----
// Fiber control and status register bank with APB access
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module fcs_regs
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              anegDefaultStrap,
  input  wire fcs_link_s         linkIn,
  output fcs_ctrl_s              ctrlOut,
  output logic                   anegRestart,
  output logic                   fiberSwReset,
  output logic                   linkDrop
);

  // Elaboration check: the map needs index bits 6:2
  if (ADDR_W < 7) begin : g_addr_chk
    $error("fcs_regs: ADDR_W must be at least 7");
  end

  // Address decode, shared by read and write paths
  // Registers 0, 1 and 16 answer only on the fiber page; page select answers on all
  function automatic fcs_reg_e decode(input logic [ADDR_W-1:0] a, input logic [7:0] pg);
    fcs_reg_e r;
    r = FCS_NONE;
    // Bits above the index field must be zero; a shift keeps any legal width valid
    if (a[1:0] == 2'h0 && (a >> 7) == '0) begin
      if (a[6:2] == IDX_PAGE) begin
        r = FCS_PAGE;
      end else if (pg != FIBER_PAGE) begin
        r = FCS_OTHER;
      end else if (a[6:2] == IDX_CTRL) begin
        r = FCS_CTRL;
      end else if (a[6:2] == IDX_STAT) begin
        r = FCS_STAT;
      end else if (a[6:2] == IDX_MODE) begin
        r = FCS_MODE;
      end
    end
    return r;
  endfunction

  // Synchroniser stages for pins from the link side
  // Only the second stage is read by logic; the first may be metastable
  fcs_link_s  linkMeta;
  fcs_link_s  linkSync;
  logic       strapMeta;
  logic       strapSync;

  // Stored register fields
  // Restart and reset bits are held for one cycle by their pending flops
  logic [7:0] page;
  logic [1:0] mode;
  logic       anegEn;
  logic       pdown;
  logic       loopback;
  logic       duplexReg;
  logic       spdHiReg;
  logic       spdLoReg;
  logic       restartPend;
  logic       swResetPend;
  logic [1:0] strapCnt;
  logic       linkLatch;
  logic       faultLatch;

  // Bus handshake terms
  // Combinational helpers, decoded from the current request and the stored fields
  logic       access;
  logic       commit;
  logic       wrCommit;
  logic       statRead;
  fcs_reg_e   target;
  logic       isFx;
  logic       isSgmii;
  logic       enChange;
  logic       pdExit;
  logic       hostSwRst;
  logic       hostRestart;
  logic       spdHi;
  logic       spdLo;
  logic [15:0] ctrlWord;
  logic [15:0] statWord;

  // Two flops before any logic looks at the pins
  // Frozen with ce like every other flop, so a stalled bank keeps its view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkMeta  <= '0;
      linkSync  <= '0;
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else if (ce) begin
      linkMeta  <= linkIn;
      linkSync  <= linkMeta;
      strapMeta <= anegDefaultStrap;
      strapSync <= strapMeta;
    end
  end

  // Access decode; commit is the edge at which the master samples pready
  // Writes and read-clears act only at that edge, so a stretched access is harmless
  assign access   = psel && penable;
  assign commit   = access && pready;
  assign target   = decode(paddr, page);
  assign wrCommit = commit && pwrite;
  assign statRead = commit && !pwrite && target == FCS_STAT;
  assign isFx     = mode == MODE_FX;
  assign isSgmii  = mode[1];

  // Host-side events from a write of the control word
  // A write on another page decodes as FCS_OTHER and raises nothing
  assign hostSwRst   = wrCommit && target == FCS_CTRL && pwdata[C_SWRST];
  assign hostRestart = wrCommit && target == FCS_CTRL && pwdata[C_RESTART];
  // Enable change counts only outside FX mode, where the bit is ignored
  assign enChange = wrCommit && target == FCS_CTRL && !isFx
                    && pwdata[C_ANEG_EN] != anegEn;
  // Leaving power-down, whether by write or by software reset
  assign pdExit = pdown && ((wrCommit && target == FCS_CTRL && !pwdata[C_PDOWN])
                            || swResetPend);

  // Speed bits depend on the fiber mode
  // In system SGMII mode the bits mirror the live link speed
  // Mode 11 reads back the host-written holding bits
  always_comb begin
    unique case (mode)
      MODE_FX: begin
        spdHi = 1'b0;
        spdLo = 1'b1;
      end
      MODE_1000X: begin
        spdHi = 1'b1;
        spdLo = 1'b0;
      end
      MODE_SGSYS: begin
        spdHi = linkSync.atGig;
        spdLo = linkSync.atFast;
      end
      MODE_SGMED: begin
        spdHi = spdHiReg;
        spdLo = spdLoReg;
      end
    endcase
  end

  // Control word as read back
  // Isolate, collision test and the low reserved bits stay zero
  always_comb begin
    ctrlWord            = '0;
    ctrlWord[C_SWRST]   = swResetPend;
    ctrlWord[C_LOOP]    = loopback;
    ctrlWord[C_SPD_LO]  = spdLo;
    ctrlWord[C_ANEG_EN] = anegEn;
    ctrlWord[C_PDOWN]   = pdown;
    ctrlWord[C_RESTART] = restartPend;
    ctrlWord[C_DUPLEX]  = duplexReg;
    ctrlWord[C_SPD_HI]  = spdHi;
  end

  // Status word; unlisted ability bits stay zero
  // Autoneg complete is masked when bypass brought the link up
  always_comb begin
    statWord            = '0;
    statWord[S_X_FD]    = isFx;
    statWord[S_X_HD]    = isFx;
    statWord[S_EXT_ST]  = 1'b1;
    statWord[S_NOPRE]   = 1'b1;
    statWord[S_AN_DONE] = linkSync.anegDone && ctrlOut.anegEnable
                          && !linkSync.anegBypass;
    statWord[S_RFAULT]  = faultLatch && !isSgmii;
    statWord[S_AN_ABLE] = !isFx;
    statWord[S_LINK]    = linkLatch;
    statWord[S_EXT_CAP] = 1'b1;
  end

  // Page select lives on every page
  // Software reset leaves the page alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page <= RST_PAGE;
    end else if (ce && wrCommit && target == FCS_PAGE) begin
      page <= pwdata[7:0];
    end
  end

  // Fiber mode field; retained over software reset
  // Values are not checked: every code of the field has a meaning
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= RST_MODE;
    end else if (ce && wrCommit && target == FCS_MODE) begin
      mode <= pwdata[1:0];
    end
  end

  // Strap is caught after the synchroniser has filled, never under reset
  // The second stage is zero out of reset, so loading runs for three edges
  // and the last load sees a strap that has passed both flops
  // Host writes are not taken while loading; none can commit that early
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapCnt <= '0;
      anegEn   <= 1'b0;
    end else if (ce) begin
      if (strapCnt <= STRAP_SETTLE) begin
        strapCnt <= strapCnt + 2'h1;
        anegEn   <= strapSync;
      end else if (enChange) begin
        anegEn   <= pwdata[C_ANEG_EN];
      end
    end
  end

  // Power-down and loopback clear on software reset; writes may still set them
  // A write that also asks for reset stores nothing here; the reset clears
  // both bits one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdown    <= 1'b0;
      loopback <= 1'b0;
    end else if (ce) begin
      if (wrCommit && target == FCS_CTRL && !pwdata[C_SWRST]) begin
        pdown    <= pwdata[C_PDOWN];
        loopback <= pwdata[C_LOOP];
      end else if (swResetPend) begin
        pdown    <= 1'b0;
        loopback <= 1'b0;
      end
    end
  end

  // Duplex and speed holding bits; retained over software reset
  // The duplex bit is stored at once but reaches ctrlOut only on a restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplexReg <= RST_DUPLEX;
      spdHiReg  <= RST_SPD_HI;
      spdLoReg  <= RST_SPD_LO;
    end else if (ce && wrCommit && target == FCS_CTRL) begin
      duplexReg <= pwdata[C_DUPLEX];
      if (mode == MODE_SGMED) begin
        spdHiReg <= pwdata[C_SPD_HI];
        spdLoReg <= pwdata[C_SPD_LO];
      end
    end
  end

  // Self-clearing software reset: one cycle pending, new request wins
  // A power-down exit raises one pending cycle; the guard stops the reset
  // it causes from re-triggering itself through pdExit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swResetPend  <= 1'b0;
      fiberSwReset <= 1'b0;
    end else if (ce) begin
      swResetPend  <= hostSwRst || (pdExit && !swResetPend);
      fiberSwReset <= swResetPend;
    end
  end

  // Restart pending; set from hw reset and every trigger, cleared once issued
  // Pending reads back as the restart bit, so it shows one until the restart is issued
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restartPend <= 1'b1;
      anegRestart <= 1'b0;
      linkDrop    <= 1'b0;
    end else if (ce) begin
      // Set beats the self-clear so a fresh trigger is never lost
      restartPend <= hostRestart || enChange || swResetPend || pdExit;
      anegRestart <= restartPend;
      linkDrop    <= enChange;
    end
  end

  // Effective controls; duplex is only applied when a restart is issued
  // Enable is forced low in FX mode without touching the stored bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlOut <= '{anegEnable: 1'b0, fullDuplex: RST_DUPLEX, powerDown: 1'b0,
                   loopback: 1'b0, speed: {RST_SPD_HI, RST_SPD_LO}};
    end else if (ce) begin
      ctrlOut.anegEnable <= anegEn && !isFx;
      ctrlOut.powerDown  <= pdown;
      ctrlOut.loopback   <= loopback;
      ctrlOut.speed      <= {spdHi, spdLo};
      if (restartPend) begin
        ctrlOut.fullDuplex <= duplexReg;
      end
    end
  end

  // Link status latches low; a status read reloads the live value
  // A loss during the read cycle reloads as zero, so it is never missed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkLatch <= 1'b0;
    end else if (ce) begin
      if (statRead) begin
        linkLatch <= linkSync.linkUp;
      end else if (!linkSync.linkUp) begin
        linkLatch <= 1'b0;
      end
    end
  end

  // Remote fault latches high; a new fault in the read cycle is kept
  // In SGMII modes the latch still runs but the read path masks it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultLatch <= 1'b0;
    end else if (ce) begin
      faultLatch <= linkSync.remoteFault || (faultLatch && !statRead);
    end
  end

  // APB answer: one wait state, read data captured with pready
  // Data are taken at the first access edge; read-clear side effects wait
  // for the commit edge, so the word the master sees is the one that cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (access && !pready) begin
        pready  <= 1'b1;
        pslverr <= target == FCS_NONE;
        unique case (target)
          FCS_CTRL: prdata <= {16'h0000, ctrlWord};
          FCS_STAT: prdata <= {16'h0000, statWord};
          FCS_MODE: prdata <= {30'h0000_0000, mode};
          FCS_PAGE: prdata <= {24'h00_0000, page};
          FCS_OTHER, FCS_NONE: prdata <= '0;
        endcase
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // fcs_regs

// ---- design/fcs_pkg.sv ----
// Package with register map, field positions and carriers for the fiber control/status bank
package fcs_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [4:0] IDX_CTRL   = 5'h00;
  localparam logic [4:0] IDX_STAT   = 5'h01;
  localparam logic [4:0] IDX_MODE   = 5'h10;
  localparam logic [4:0] IDX_PAGE   = 5'h16;
  localparam logic [7:0] FIBER_PAGE = 8'h01;

  // Fiber control field positions
  localparam int C_SWRST   = 15;
  localparam int C_LOOP    = 14;
  localparam int C_SPD_LO  = 13;
  localparam int C_ANEG_EN = 12;
  localparam int C_PDOWN   = 11;
  localparam int C_RESTART = 9;
  localparam int C_DUPLEX  = 8;
  localparam int C_SPD_HI  = 6;

  // Fiber status field positions
  localparam int S_X_FD    = 14;
  localparam int S_X_HD    = 13;
  localparam int S_EXT_ST  = 8;
  localparam int S_NOPRE   = 6;
  localparam int S_AN_DONE = 5;
  localparam int S_RFAULT  = 4;
  localparam int S_AN_ABLE = 3;
  localparam int S_LINK    = 2;
  localparam int S_EXT_CAP = 0;

  // Fiber mode field encodings
  localparam logic [1:0] MODE_FX    = 2'h0;
  localparam logic [1:0] MODE_1000X = 2'h1;
  localparam logic [1:0] MODE_SGSYS = 2'h2;
  localparam logic [1:0] MODE_SGMED = 2'h3;

  // Hardware reset values
  localparam logic       RST_DUPLEX = 1'h1;
  localparam logic       RST_SPD_HI = 1'h1;
  localparam logic       RST_SPD_LO = 1'h0;
  localparam logic [1:0] RST_MODE   = 2'h1;
  localparam logic [7:0] RST_PAGE   = 8'h00;

  // Cycles after reset release before the synchronised strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Live status from the fiber link logic (asynchronous to clk)
  typedef struct packed {
    logic linkUp;
    logic anegDone;
    logic anegBypass;
    logic remoteFault;
    logic atGig;
    logic atFast;
  } fcs_link_s;

  // Effective controls handed to the fiber link logic
  typedef struct packed {
    logic       anegEnable;
    logic       fullDuplex;
    logic       powerDown;
    logic       loopback;
    logic [1:0] speed;
  } fcs_ctrl_s;

  // Decoded register target
  typedef enum logic [2:0] {
    FCS_NONE, FCS_CTRL, FCS_STAT, FCS_MODE, FCS_PAGE, FCS_OTHER
  } fcs_reg_e;

endpackage

// ---- tb/fcs_regs_checker.sv ----
// Assertion checker for the fiber control/status bank, bound to its ports
`timescale 1ns/100ps
module fcs_regs_checker
  import fcs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire fcs_ctrl_s         ctrlOut,
  input wire logic              anegRestart,
  input wire logic              fiberSwReset,
  input wire logic              linkDrop
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answers: single-cycle ready, refused addresses give zero data
  property p_ack_once;
    pready |=> !pready;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ready held too long");
  property p_bad_addr;
    psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address not refused");
  // Fixed fields of both registers, whatever the mode; status only when read on the fiber page
  property p_ctrl_ro;
    pready && !pwrite && paddr == '0 |-> prdata[10] == 1'b0 && prdata[7] == 1'b0
      && prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000;
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("control fixed bits wrong");
  property p_stat_fixed;
    pready && !pwrite && paddr == ADDR_W'(4) && prdata[0] |-> prdata[15] == 1'b0
      && prdata[12:9] == 4'h0 && prdata[8] && prdata[6] && prdata[14] == prdata[13]
      && prdata[14] != prdata[3];
  endproperty
  a_stat_fixed: assert property (p_stat_fixed) else $error("status fixed bits wrong");
  // Control events must be acted on within a few cycles of the commit
  property p_swrst_req;
    psel && penable && pready && pwrite && paddr == '0 && pwdata[15] |-> ##[1:3] fiberSwReset;
  endproperty
  a_swrst_req: assert property (p_swrst_req) else $error("reset write not acted on");
  property p_restart_req;
    psel && penable && pready && pwrite && paddr == '0 && pwdata[9] |-> ##[1:3] anegRestart;
  endproperty
  a_restart_req: assert property (p_restart_req) else $error("restart write lost");
  property p_swrst_restart;
    fiberSwReset |-> ##[0:3] anegRestart;
  endproperty
  a_swrst_restart: assert property (p_swrst_restart) else $error("no restart after reset");
  property p_drop_restart;
    linkDrop |-> ##[0:3] anegRestart;
  endproperty
  a_drop_restart: assert property (p_drop_restart) else $error("no restart after drop");
  // Duplex may only move alongside a restart
  property p_dup_defer;
    $changed(ctrlOut.fullDuplex) |-> (anegRestart || $past(anegRestart)) or (##[1:3] anegRestart);
  endproperty
  a_dup_defer: assert property (p_dup_defer) else $error("duplex moved alone");
endmodule // fcs_regs_checker

bind fcs_regs fcs_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .ctrlOut(ctrlOut), .anegRestart(anegRestart),
  .fiberSwReset(fiberSwReset), .linkDrop(linkDrop));

// ---- tb/fcs_regs_bench.sv ----
// Self-checking bench for the fiber control/status register bank
`timescale 1ns/100ps
module fcs_regs_bench
  import fcs_pkg::*;
;
  localparam logic [7:0] A_CTRL = {1'b0, IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {1'b0, IDX_STAT, 2'b00};
  localparam logic [7:0] A_MODE = {1'b0, IDX_MODE, 2'b00};
  localparam logic [7:0] A_PAGE = {1'b0, IDX_PAGE, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        strap = 1'b1;
  logic        ce = 1'b1;
  fcs_link_s   link = 6'h32; // Link up, negotiated, gigabit
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  fcs_ctrl_s   ctrlOut;
  logic        anegRestart;
  logic        fiberSwReset;
  logic        linkDrop;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic        errQ[$];
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 29916;
  int          nRst = 0;
  int          nSw = 0;
  int          nDrop = 0;
  int          r0, s0, d0;

  fcs_regs #(.ADDR_W(8)) uut (
    .clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .anegDefaultStrap(strap), .linkIn(link), .ctrlOut(ctrlOut), .anegRestart(anegRestart),
    .fiberSwReset(fiberSwReset), .linkDrop(linkDrop));

  always #25 clk = ~clk;

  // Pulse counters and the run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nRst <= nRst + int'(anegRestart === 1'b1);
    nSw <= nSw + int'(fiberSwReset === 1'b1);
    nDrop <= nDrop + int'(linkDrop === 1'b1);
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  // Each answer is compared with the oldest note the driver left
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expQ.size() == 0) begin
        fail(32'h0000_0000, prdata);
      end else begin
        chk(prdata & mskQ.pop_front(), expQ.pop_front());
        chk(32'(pslverr), 32'(errQ.pop_front()));
      end
    end
  end

  task automatic fail(input logic [31:0] e, input logic [31:0] g);
    n_errors = n_errors + 1;
    $display("[FAIL] %0t exp %h got %h", $time, e, g);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) fail(e, g);
  endtask
  task automatic note(input logic [31:0] e, input logic [31:0] m, input logic er);
    expQ.push_back(e);
    mskQ.push_back(m);
    errQ.push_back(er);
  endtask
  // Setup then access; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'($random(seed)), d}; // Upper half is don't-care, so randomise it
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail(32'h0000_0001, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    note(e, m, er);
    apb(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    note(32'h0000_0000, 32'h0000_0000, 1'b0);
    apb(1'b1, a, d);
  endtask
  // Let synchronisers and event pulses finish
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic blip(input int k);
    link[k] <= ~link[k];
    repeat (4) @(posedge clk);
    link[k] <= ~link[k];
    settle();
  endtask
  task automatic snap();
    r0 = nRst;
    s0 = nSw;
    d0 = nDrop;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(A_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    wr(A_PAGE, 16'h0001);
    rd(A_PAGE, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
    rd(A_CTRL, 32'h0000_1140, 32'hFFFF_FFFF, 1'b0);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      wr(A_MODE, 16'(i));
      rd(A_STAT, (i == 0) ? 32'h0000_6141 : 32'h0000_0149, 32'hFFFF_FFCB, 1'b0);
      rd(A_CTRL, (i == 0) ? 32'h0000_2000 : 32'h0000_0040, 32'h0000_2040, 1'b0);
      chk(32'(ctrlOut.speed), (i == 0) ? 32'h0000_0001 : 32'h0000_0002);
    end
    wr(A_CTRL, 16'h3100);
    rd(A_CTRL, 32'h0000_2000, 32'h0000_2040, 1'b0);
    wr(A_CTRL, 16'h1100);
    rd(A_CTRL, 32'h0000_0000, 32'h0000_2040, 1'b0);
    wr(A_MODE, 16'h0001);
    done("modes");
    snap();
    wr(A_CTRL, 16'h1340);
    settle();
    chk(32'(nRst - r0), 32'h0000_0001);
    rd(A_CTRL, 32'h0000_1000, 32'h0000_1200, 1'b0);
    wr(A_CTRL, 16'h1040);
    settle();
    chk(32'(ctrlOut.fullDuplex), 32'h0000_0001);
    rd(A_CTRL, 32'h0000_0000, 32'h0000_0100, 1'b0);
    wr(A_CTRL, 16'h1240);
    settle();
    chk(32'(ctrlOut.fullDuplex), 32'h0000_0000);
    done("restart");
    snap();
    wr(A_CTRL, 16'h0040);
    settle();
    chk(32'(nDrop - d0), 32'h0000_0001);
    chk(32'(nRst > r0), 32'h0000_0001);
    chk(32'(ctrlOut.anegEnable), 32'h0000_0000);
    wr(A_MODE, 16'h0000);
    settle();
    snap();
    wr(A_CTRL, 16'h1040);
    settle();
    rd(A_CTRL, 32'h0000_0000, 32'h0000_1000, 1'b0);
    chk(32'(nDrop - d0), 32'h0000_0000);
    chk(32'(ctrlOut.anegEnable), 32'h0000_0000);
    wr(A_MODE, 16'h0001);
    wr(A_CTRL, 16'h1040);
    settle();
    chk(32'(ctrlOut.anegEnable), 32'h0000_0001);
    done("enable");
    wr(A_CTRL, 16'h5840);
    settle();
    chk(32'(ctrlOut.powerDown), 32'h0000_0001);
    chk(32'(ctrlOut.loopback), 32'h0000_0001); // Loopback reaches the link side
    snap();
    wr(A_CTRL, 16'h1040);
    settle();
    chk(32'(nSw > s0), 32'h0000_0001);
    chk(32'(nRst > r0), 32'h0000_0001);
    snap();
    wr(A_CTRL, 16'h9040);
    settle();
    chk(32'(nSw - s0), 32'h0000_0001);
    rd(A_CTRL, 32'h0000_1000, 32'h0000_9000, 1'b0);
    done("resets");
    blip(5); // Link loss
    rd(A_STAT, 32'h0000_0000, 32'h0000_0004, 1'b0);
    rd(A_STAT, 32'h0000_0004, 32'h0000_0004, 1'b0);
    blip(2); // Remote fault
    rd(A_STAT, 32'h0000_0010, 32'h0000_0010, 1'b0);
    rd(A_STAT, 32'h0000_0000, 32'h0000_0010, 1'b0);
    rd(A_STAT, 32'h0000_0020, 32'h0000_0020, 1'b0);
    link.anegBypass <= 1'b1; // Bypass while negotiation still reports done
    settle();
    rd(A_STAT, 32'h0000_0000, 32'h0000_0020, 1'b0);
    wr(A_MODE, 16'h0002);
    blip(2);
    rd(A_STAT, 32'h0000_0000, 32'h0000_0010, 1'b0);
    link.anegBypass <= 1'b0;
    wr(A_CTRL, 16'h0040);
    settle();
    rd(A_STAT, 32'h0000_0000, 32'h0000_0020, 1'b0);
    done("status");
    ce <= 1'b0;
    blip(5); // Link loss while frozen must not reach the latch
    ce <= 1'b1;
    rd(A_STAT, 32'h0000_0004, 32'h0000_0004, 1'b0);
    done("freeze");
    rd(8'h03, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    note(32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h81, 16'hFFFF);
    wr(A_PAGE, 16'h0002);
    rd(A_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    done("access");
    settle();
    give_verdict();
  end
endmodule // fcs_regs_bench
